// >>> rtl/ebsd_ctrl.sv
/*
 * External bus controller core: normal, DRAM and continuous sdram cycles,
 * idle-cycle pin levels and the write data buffer grant to internal accesses.
 * Assumes request and configuration inputs are on REF_CLK; WAIT_N and DATA_IN
 * come from pins and are synchronised here.
 */
`timescale 1ns/1ps
// Summary of operation
// R1 - space select field maps areas 2..5 to DRAM, sdram or sdram mode setting
// R2 - sdram space is at most 8 Mbytes
// R3 - sdram reads accept CAS latency 1 to 4
// R4 - sdram space reuses chip selects 2-4 as RAS/CAS/WE, OE as CKE, 5 as clock
// R5 - sdram accesses use the bus setup of area 2
// R6 - sdram accesses ignore wait pin and programmed waits
// R7 - sdram command is RAS/CAS/WE levels plus precharge select on upper column line
// R8 - idle cycle shows next cycle address and floats the data bus
// R9 - idle cycle drives strobes high, chip select low in RAS-down mode
// R10 - idle cycle inside DRAM refresh keeps chip select and CAS strobes low
// R11 - write buffer only active while its enable bit is 1
// R12 - buffered write runs alone in first state, then internal access in parallel
// R13 - unbuffered write holds internal access until it completes
module ebsd_ctrl
    import ebsd_pkg::*;
(
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    // configuration
    input  wire logic        SPACE_SELECT_BIT2,
    input  wire logic        SPACE_SELECT_BIT1,
    input  wire logic        SPACE_SELECT_BIT0,
    input  wire logic [1:0]  CAS_LATENCY,
    input  wire logic [15:0] AREA_WAIT,
    input  wire logic        RAS_DOWN_MODE,
    input  wire logic        REFRESH_ACTIVE,
    input  wire logic        WRITE_BUFFER_ENABLE,
    // bus cycle request
    input  wire logic        REQ_VALID,
    input  wire logic        REQ_WRITE,
    input  wire logic [23:0] REQ_ADDR,
    input  wire logic [2:0]  REQ_AREA,
    input  wire logic [1:0]  REQ_BE,
    input  wire logic [15:0] REQ_WDATA,
    input  wire logic        REQ_DMA,
    input  wire logic [1:0]  REQ_DMA_CH,
    input  wire logic [2:0]  REQ_SD_CMD,
    input  wire logic        REQ_PRE_SEL,
    output logic             REQ_READY,
    output logic             DONE,
    output logic [15:0]      RDATA,
    // internal access arbitration
    input  wire logic        INT_REQ,
    output logic             INT_GRANT,
    // external pins
    input  wire logic        WAIT_N,
    input  wire logic [15:0] DATA_IN,
    output logic [15:0]      DATA_OUT,
    output logic             DATA_OE,
    output logic [23:0]      ADDR,
    output logic [7:0]       CHIP_SELECT_N,
    output logic             UPPER_BYTE_COL_STROBE_N,
    output logic             LOWER_BYTE_COL_STROBE_N,
    output logic             ADDRESS_STROBE_N,
    output logic             READ_STROBE_N,
    output logic             OUTPUT_ENABLE_N,
    output logic             HIGH_BYTE_WRITE_STROBE_N,
    output logic             LOW_BYTE_WRITE_STROBE_N,
    output logic [1:0]       DMA_ACKNOWLEDGE_N,
    output logic [1:0]       EXT_DMA_ACKNOWLEDGE_N
);
    ebsd_state_t state, next_state;
    logic [2:0]  sel;
    logic        sdram_mode;
    logic [1:0]  req_kind;
    logic        taken;
    logic        wait_n_s;
    logic [15:0] data_s;
    logic [2:0]  cnt, next_cnt;
    logic        phase, next_phase;
    logic [23:0] c_addr, next_c_addr;
    logic        c_write, next_c_write;
    logic [1:0]  c_be, next_c_be;
    logic [15:0] c_wdata, next_c_wdata;
    logic [2:0]  c_area, next_c_area;
    logic [1:0]  c_kind, next_c_kind;
    logic        c_dma, next_c_dma;
    logic [1:0]  c_ch, next_c_ch;
    logic [2:0]  c_cmd, next_c_cmd;
    logic        c_pre, next_c_pre;
    logic        next_done;
    logic [15:0] next_rdata;
    logic        next_grant;
    logic [7:0]  n_cs;
    logic        n_upper_byte_col_strobe, n_lower_byte_col_strobe, n_as, n_rd, n_oe, n_hwr, n_lwr, n_doe;
    logic [1:0]  n_dack, n_edack;
    logic [23:0] n_addr;
    logic [2:0]  cfg_area;

    // pins from outside pass two flip-flops first
    ebsd_sync #(.W(17)) u_sync (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .d     ({WAIT_N, DATA_IN}),
        .q     ({wait_n_s, data_s})
    );

    assign sel        = {SPACE_SELECT_BIT2, SPACE_SELECT_BIT1, SPACE_SELECT_BIT0};
    assign sdram_mode = (sel == SEL_SDRAM) || (sel == SEL_SDRAM_MODE); // [R1]
    assign req_kind   = ebsd_area_kind(sel, REQ_AREA); // [R1]
    // sdram commands start only when the next clock phase is low
    assign taken      = REQ_VALID && REQ_READY && (req_kind != KIND_SDRAM || phase);
    // sdram space borrows the area 2 setup, whose waits are then dropped
    assign cfg_area   = (c_kind == KIND_SDRAM) ? AREA_SDRAM_CFG : c_area; // [R5]

    // cycle sequencing and next pin levels
    always_comb begin
        next_state   = state;
        next_cnt     = cnt;
        next_phase   = sdram_mode ? ~phase : 1'b0; // divider for memory clock
        next_c_addr  = c_addr;
        next_c_write = c_write;
        next_c_be    = c_be;
        next_c_wdata = c_wdata;
        next_c_area  = c_area;
        next_c_kind  = c_kind;
        next_c_dma   = c_dma;
        next_c_ch    = c_ch;
        next_c_cmd   = c_cmd;
        next_c_pre   = c_pre;
        next_done    = 1'b0;
        next_rdata   = RDATA;
        unique case (state)
            ST_IDLE: begin
                if (taken) begin
                    next_c_addr  = REQ_ADDR;
                    next_c_write = REQ_WRITE;
                    next_c_be    = REQ_BE;
                    next_c_wdata = REQ_WDATA;
                    next_c_area  = REQ_AREA;
                    next_c_kind  = req_kind;
                    next_c_dma   = REQ_DMA;
                    next_c_ch    = REQ_DMA_CH;
                    next_c_cmd   = REQ_SD_CMD;
                    next_c_pre   = REQ_PRE_SEL;
                    next_state   = (req_kind == KIND_SDRAM) ? ST_SD_CMD : ST_T1;
                end
            end
            ST_T1: begin
                next_state = ST_T2;
                next_cnt   = {1'b0, AREA_WAIT[{cfg_area, 1'b0} +: 2]};
            end
            ST_T2: begin
                if (cnt != RST_CNT) begin
                    next_cnt = cnt - 3'h1;
                end else if (wait_n_s) begin
                    next_state = ST_IDLE;
                    next_done  = 1'b1;
                    next_rdata = c_write ? RDATA : data_s;
                end
            end
            ST_SD_CMD: begin
                // no program or pin wait: one memory clock per command [R6]
                if (phase) begin
                    if (c_cmd == SD_CMD_READ) begin
                        next_state = ST_SD_LAT;
                        next_cnt   = {1'b0, CAS_LATENCY}; // [R3]
                    end else begin
                        next_state = ST_IDLE;
                        next_done  = 1'b1;
                    end
                end
            end
            ST_SD_LAT: begin
                // one count per memory clock rise, data on the last [R3]
                if (phase) begin
                    if (cnt == RST_CNT) begin
                        next_state = ST_IDLE;
                        next_done  = 1'b1;
                        next_rdata = data_s;
                    end else begin
                        next_cnt = cnt - 3'h1;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase

        n_cs    = RST_CS;
        n_upper_byte_col_strobe  = 1'b1;
        n_lower_byte_col_strobe  = 1'b1;
        n_as    = 1'b1;
        n_rd    = 1'b1;
        n_oe    = 1'b1;
        n_hwr   = 1'b1;
        n_lwr   = 1'b1;
        n_dack  = RST_ACK;
        n_edack = RST_ACK;
        n_doe   = 1'b0;
        n_addr  = next_c_addr;
        if (next_state == ST_IDLE) begin
            // address runs ahead, data bus floats [R8]
            n_addr = REQ_VALID ? REQ_ADDR : next_c_addr; // [R8]
            if (RAS_DOWN_MODE && next_c_kind == KIND_DRAM) begin
                n_cs[next_c_area] = 1'b0; // [R9]
            end
            if (REFRESH_ACTIVE) begin
                n_cs[AREA_FIRST] = 1'b0; // [R10]
                n_upper_byte_col_strobe           = 1'b0; // [R10]
                n_lower_byte_col_strobe           = 1'b0;
            end
        end else begin
            if (next_c_dma) begin
                if (next_c_ch[1]) n_edack[next_c_ch[0]] = 1'b0;
                else              n_dack[next_c_ch[0]]  = 1'b0;
            end
            if (next_state == ST_T1 || next_state == ST_T2) begin
                n_cs[next_c_area] = 1'b0;
                n_as              = 1'b0;
            end
            if (next_state == ST_T2) begin
                if (next_c_kind == KIND_DRAM) begin
                    n_upper_byte_col_strobe = ~next_c_be[1];
                    n_lower_byte_col_strobe = ~next_c_be[0];
                end
                if (next_c_write) begin
                    n_doe = 1'b1;
                    if (next_c_kind != KIND_DRAM) begin
                        n_hwr = ~next_c_be[1];
                        n_lwr = ~next_c_be[0];
                    end
                end else begin
                    n_rd = 1'b0;
                    n_oe = 1'b0;
                end
            end
        end
        if (sdram_mode) begin
            // pins take their memory roles [R4]
            n_cs[CS_RAS]   = 1'b1;
            n_cs[CS_CAS]   = 1'b1;
            n_cs[CS_WE]    = 1'b1;
            n_cs[CS_SDCLK] = next_phase; // [R4]
            n_oe           = 1'b1; // clock enable held active [R4]
            if (next_state == ST_SD_CMD) begin
                n_cs[CS_RAS] = next_c_cmd[2]; // [R7]
                n_cs[CS_CAS] = next_c_cmd[1]; // [R7]
                n_cs[CS_WE]  = next_c_cmd[0]; // [R7]
                n_addr       = next_c_addr & SD_ADDR_MASK; // [R2]
                n_addr[PRE_SEL_BIT] = next_c_pre; // [R7]
                n_doe        = (next_c_cmd == SD_CMD_WRITE);
            end
        end
        // internal access: parallel after the first write state only when buffered
        next_grant = INT_REQ && (next_state == ST_IDLE
                     || (WRITE_BUFFER_ENABLE && next_c_write && next_state == ST_T2)); // [R11] [R12] [R13]
    end

    // state, cycle context and registered pins
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state                    <= ST_IDLE;
            cnt                      <= RST_CNT;
            phase                    <= 1'b0;
            c_addr                   <= RST_ADDR;
            c_write                  <= 1'b0;
            c_be                     <= 2'h0;
            c_wdata                  <= RST_DATA;
            c_area                   <= 3'h0;
            c_kind                   <= KIND_NORMAL;
            c_dma                    <= 1'b0;
            c_ch                     <= 2'h0;
            c_cmd                    <= SD_CMD_NOP;
            c_pre                    <= 1'b0;
            REQ_READY                <= 1'b0;
            DONE                     <= 1'b0;
            RDATA                    <= RST_DATA;
            INT_GRANT                <= 1'b0;
            DATA_OUT                 <= RST_DATA;
            DATA_OE                  <= 1'b0;
            ADDR                     <= RST_ADDR;
            CHIP_SELECT_N            <= RST_CS;
            UPPER_BYTE_COL_STROBE_N  <= 1'b1;
            LOWER_BYTE_COL_STROBE_N  <= 1'b1;
            ADDRESS_STROBE_N         <= 1'b1;
            READ_STROBE_N            <= 1'b1;
            OUTPUT_ENABLE_N          <= 1'b1;
            HIGH_BYTE_WRITE_STROBE_N <= 1'b1;
            LOW_BYTE_WRITE_STROBE_N  <= 1'b1;
            DMA_ACKNOWLEDGE_N        <= RST_ACK;
            EXT_DMA_ACKNOWLEDGE_N    <= RST_ACK;
        end else begin
            state                    <= next_state;
            cnt                      <= next_cnt;
            phase                    <= next_phase;
            c_addr                   <= next_c_addr;
            c_write                  <= next_c_write;
            c_be                     <= next_c_be;
            c_wdata                  <= next_c_wdata;
            c_area                   <= next_c_area;
            c_kind                   <= next_c_kind;
            c_dma                    <= next_c_dma;
            c_ch                     <= next_c_ch;
            c_cmd                    <= next_c_cmd;
            c_pre                    <= next_c_pre;
            REQ_READY                <= (next_state == ST_IDLE);
            DONE                     <= next_done;
            RDATA                    <= next_rdata;
            INT_GRANT                <= next_grant;
            DATA_OUT                 <= next_c_wdata;
            DATA_OE                  <= n_doe;
            ADDR                     <= n_addr;
            CHIP_SELECT_N            <= n_cs;
            UPPER_BYTE_COL_STROBE_N  <= n_upper_byte_col_strobe;
            LOWER_BYTE_COL_STROBE_N  <= n_lower_byte_col_strobe;
            ADDRESS_STROBE_N         <= n_as;
            READ_STROBE_N            <= n_rd;
            OUTPUT_ENABLE_N          <= n_oe;
            HIGH_BYTE_WRITE_STROBE_N <= n_hwr;
            LOW_BYTE_WRITE_STROBE_N  <= n_lwr;
            DMA_ACKNOWLEDGE_N        <= n_dack;
            EXT_DMA_ACKNOWLEDGE_N    <= n_edack;
        end
    end

    // checks on the driven pins, the internal grant and the sdram cycle timing
    a_cke_held_high: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R4]
        sdram_mode |=> OUTPUT_ENABLE_N) else $error("clock enable dropped in sdram space");
    a_idle_data_float: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R8]
        state == ST_IDLE |-> !DATA_OE) else $error("data bus driven in idle");
    a_idle_strobes_high: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R9]
        state == ST_IDLE |-> ADDRESS_STROBE_N && READ_STROBE_N && HIGH_BYTE_WRITE_STROBE_N
        && LOW_BYTE_WRITE_STROBE_N && (&DMA_ACKNOWLEDGE_N) && (&EXT_DMA_ACKNOWLEDGE_N))
        else $error("strobe low in idle");
    a_refresh_cas_low: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R10]
        state == ST_IDLE && $past(REFRESH_ACTIVE) && !$past(sdram_mode)
        |-> !UPPER_BYTE_COL_STROBE_N && !LOWER_BYTE_COL_STROBE_N && !CHIP_SELECT_N[CS_RAS])
        else $error("refresh strobes released in idle");
    a_nobuf_grant_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R13]
        !$past(WRITE_BUFFER_ENABLE) && state != ST_IDLE |-> !INT_GRANT)
        else $error("internal access during unbuffered cycle");
    a_buf_first_state: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R12]
        state == ST_T1 |-> !INT_GRANT) else $error("internal access in first write state");
    a_buf_parallel: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R11]
        $rose(state == ST_T2) && c_write && $past(WRITE_BUFFER_ENABLE) && $past(INT_REQ)
        |-> INT_GRANT) else $error("buffered write did not release internal access");
    a_sd_cmd_length: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R6]
        $rose(state == ST_SD_CMD) |-> ##1 state == ST_SD_CMD ##1 state != ST_SD_CMD)
        else $error("sdram command not one memory clock");
    a_sd_cmd_pins: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R7]
        state == ST_SD_CMD |-> CHIP_SELECT_N[4:2] == {c_cmd[0], c_cmd[1], c_cmd[2]}
        && ADDR[PRE_SEL_BIT] == c_pre && !ADDR[23]) else $error("sdram command pins wrong");
    a_sd_latency_bound: assert property (@(posedge REF_CLK) disable iff (!RST_N) // [R3]
        $rose(state == ST_SD_LAT) |-> ##[1:8] DONE) else $error("read data late");

endmodule

// >>> rtl/ebsd_pkg.sv
/*
 * Shared constants and types for the external bus / synchronous DRAM block:
 * space select codes, area numbers, pin reassignment, command codes, reset
 * levels and the controller states.
 * Assumes a single 20 MHz system clock with a synchronous active-low reset.
 */
package ebsd_pkg;

    // system clock
    localparam int CLK_PERIOD_NS = 50;

    // space select field codes
    localparam logic [2:0] SEL_NORMAL     = 3'h0;
    localparam logic [2:0] SEL_DRAM_A2    = 3'h1;
    localparam logic [2:0] SEL_DRAM_A23   = 3'h2;
    localparam logic [2:0] SEL_DRAM_A25   = 3'h3;
    localparam logic [2:0] SEL_SDRAM      = 3'h4;
    localparam logic [2:0] SEL_SDRAM_MODE = 3'h5;

    // areas that can become memory space; area 2 supplies the sdram bus setup
    localparam logic [2:0] AREA_FIRST     = 3'h2;
    localparam logic [2:0] AREA_SECOND    = 3'h3;
    localparam logic [2:0] AREA_LAST      = 3'h5;
    localparam logic [2:0] AREA_SDRAM_CFG = 3'h2;

    // kind of space an area decodes to
    localparam logic [1:0] KIND_NORMAL = 2'h0;
    localparam logic [1:0] KIND_DRAM   = 2'h1;
    localparam logic [1:0] KIND_SDRAM  = 2'h2;

    // chip select pins reused in continuous sdram space
    localparam int CS_RAS   = 2;
    localparam int CS_CAS   = 3;
    localparam int CS_WE    = 4;
    localparam int CS_SDCLK = 5;

    // sdram space limited to 8 Mbytes, precharge select on an upper column line
    localparam logic [23:0] SD_ADDR_MASK = 24'h7fffff;
    localparam int          PRE_SEL_BIT  = 10;

    // command codes as {ras, cas, we} levels
    localparam logic [2:0] SD_CMD_NOP   = 3'h7;
    localparam logic [2:0] SD_CMD_READ  = 3'h5;
    localparam logic [2:0] SD_CMD_WRITE = 3'h4;

    // reset and idle levels
    localparam logic [7:0]  RST_CS    = 8'hff;
    localparam logic [1:0]  RST_ACK   = 2'h3;
    localparam logic [23:0] RST_ADDR  = 24'h000000;
    localparam logic [15:0] RST_DATA  = 16'h0000;
    localparam logic [2:0]  RST_CNT   = 3'h0;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_T1     = 6'h02,
        ST_T2     = 6'h04,
        ST_SD_CMD = 6'h08,
        ST_SD_LAT = 6'h10,
        ST_SPARE  = 6'h20
    } ebsd_state_t;

    // area decode from the space select field [R1]
    function automatic logic [1:0] ebsd_area_kind(input logic [2:0] sel,
                                                  input logic [2:0] area);
        logic [1:0] k;
        logic       in_range;
        k        = KIND_NORMAL;
        in_range = (area >= AREA_FIRST) && (area <= AREA_LAST);
        case (sel)
            SEL_DRAM_A2:  if (area == AREA_FIRST) k = KIND_DRAM;
            SEL_DRAM_A23: if (area == AREA_FIRST || area == AREA_SECOND) k = KIND_DRAM;
            SEL_DRAM_A25: if (in_range) k = KIND_DRAM;
            SEL_SDRAM, SEL_SDRAM_MODE: if (in_range) k = KIND_SDRAM;
            default:      k = KIND_NORMAL;
        endcase
        return k;
    endfunction

endpackage

// >>> rtl/ebsd_sync.sv
/*
 * Two flip-flop synchroniser for pin inputs of any width.
 * Assumes the inputs are quasi-static across a clock or tolerate a cycle of
 * skew between bits (bus data is only sampled once settled).
 */
`timescale 1ns/1ps
module ebsd_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // asynchronous in, synchronous out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// >>> sim/ebsd_mem_model.sv
/*
 * External memory model for the bus block: answers reads with a fixed word.
 * Assumes it samples the pins on the system clock and sees the sdram mode.
 */
`timescale 1ns/1ps
module ebsd_mem_model
    import ebsd_pkg::*;
#(
    parameter logic [15:0] PAT = 16'hc3a5
) (
    // clock and mode
    input  wire logic        clk,
    input  wire logic        sd_mode,
    input  wire logic        stall,
    // strobes from the block
    input  wire logic        rd_n,
    input  wire logic [2:0]  cmd,
    // pins back to the block
    output logic             wait_n,
    output logic [15:0]      dq
);
    logic [3:0] hold = 4'h0;

    // stall is only driven by the sdram scenario, to show that waits are ignored
    assign wait_n = !stall;
    // read data held long enough for latency 4; inverse when released
    always @(posedge clk) begin
        if (!rd_n || (sd_mode && cmd == SD_CMD_READ)) hold <= 4'hc;
        else if (hold != 4'h0) hold <= hold - 4'h1;
    end
    assign dq = (hold != 4'h0) ? PAT : ~PAT;
endmodule

// >>> sim/ebsd_ctrl_tb_top.sv
/*
 * Self-checking bench for the bus controller with a memory model.
 * Assumes a 20 MHz clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module ebsd_ctrl_tb_top;
    import ebsd_pkg::*;
    logic        clk = 0, rst_n = 0, rasdn = 0, refr = 0, wbe = 0, v = 0, w = 0;
    logic        dma = 0, pre = 0, ireq = 0, stall = 0, rdy, done, gr, waitn, doe;
    logic        upper_byte_col_strobe, lower_byte_col_strobe, asn, rdn, oen, high_byte_write_strobe, low_byte_write_strobe, sc, sw, sg, sk;
    logic [1:0]  lat = 0, be = 2'h3, ch = 0, dack, edack;
    logic [2:0]  sel = 0, ar = 0, cmd = 0;
    logic [7:0]  chip_select_n, cs1;
    logic [15:0] wt = 0, wd = 16'ha55a, rdata, din, dout;
    logic [23:0] a = 0, addr, a0, a1;
    int          cyc, checks = 0, n_fail = 0;

    always #25 clk = ~clk;

    ebsd_ctrl i_ebsd_ctrl (.REF_CLK(clk), .RST_N(rst_n), .SPACE_SELECT_BIT2(sel[2]),
        .SPACE_SELECT_BIT1(sel[1]), .SPACE_SELECT_BIT0(sel[0]), .CAS_LATENCY(lat),
        .AREA_WAIT(wt), .RAS_DOWN_MODE(rasdn), .REFRESH_ACTIVE(refr),
        .WRITE_BUFFER_ENABLE(wbe), .REQ_VALID(v), .REQ_WRITE(w), .REQ_ADDR(a),
        .REQ_AREA(ar), .REQ_BE(be), .REQ_WDATA(wd), .REQ_DMA(dma), .REQ_DMA_CH(ch),
        .REQ_SD_CMD(cmd), .REQ_PRE_SEL(pre), .REQ_READY(rdy), .DONE(done),
        .RDATA(rdata), .INT_REQ(ireq), .INT_GRANT(gr), .WAIT_N(waitn), .DATA_IN(din),
        .DATA_OUT(dout), .DATA_OE(doe), .ADDR(addr), .CHIP_SELECT_N(chip_select_n),
        .UPPER_BYTE_COL_STROBE_N(upper_byte_col_strobe), .LOWER_BYTE_COL_STROBE_N(lower_byte_col_strobe),
        .ADDRESS_STROBE_N(asn), .READ_STROBE_N(rdn), .OUTPUT_ENABLE_N(oen),
        .HIGH_BYTE_WRITE_STROBE_N(high_byte_write_strobe), .LOW_BYTE_WRITE_STROBE_N(low_byte_write_strobe),
        .DMA_ACKNOWLEDGE_N(dack), .EXT_DMA_ACKNOWLEDGE_N(edack));

    ebsd_mem_model i_ebsd_mem_model (.clk(clk), .sd_mode(sel == SEL_SDRAM), .stall(stall),
        .rd_n(rdn), .cmd({chip_select_n[2], chip_select_n[3], chip_select_n[4]}), .wait_n(waitn), .dq(din));

    task automatic wrap_up;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // one bus cycle; records what the pins showed while it ran
    task automatic req(input logic wr, input logic [2:0] area, input logic [23:0] ad,
                       input logic [2:0] sdc);
        v = 1; w = wr; ar = area; a = ad; cmd = sdc;
        cyc = 0; sc = 0; sw = 0; sg = 0; sk = 0;
        do begin
            @(posedge clk); #1;
            cyc++;
            if (cyc == 1) a0 = addr;
            if (!rdy && v) begin v = 0; cs1 = chip_select_n; a1 = addr; end
            if (!upper_byte_col_strobe) sc = 1;
            if (!high_byte_write_strobe) sw = 1;
            if (gr && !rdy && !done) sg = 1;
            if (!edack[0]) sk = 1;
        end while (!done && cyc < 40);
        `CHK(done, 1'b1)
        if (!done) wrap_up();
    endtask

    // idle pins after reset
    task automatic t_idle;
        `CHK({chip_select_n, upper_byte_col_strobe, lower_byte_col_strobe, asn, rdn, oen, high_byte_write_strobe, low_byte_write_strobe, dack, edack}, 19'h7ffff)
        `CHK(doe, 1'b0)
    endtask

    // plain write with dma ack, buffer on then off
    task automatic t_write;
        ireq = 1; wbe = 1; dma = 1; ch = 2'h2;
        req(1, 3'h0, 24'h000123, SD_CMD_NOP);
        `CHK(a0, 24'h000123)
        `CHK(sw & sk, 1'b1)
        `CHK(sg, 1'b1)
        `CHK({doe, edack}, 3'h3)
        wbe = 0; dma = 0;
        req(1, 3'h0, 24'h000456, SD_CMD_NOP);
        `CHK(sg, 1'b0)
        `CHK(sw, 1'b1)
    endtask

    // dram areas use column strobes, normal ones do not
    task automatic t_decode;
        logic [2:0] at[3] = '{3'h2, 3'h3, 3'h5};
        for (int s = 1; s <= 3; s++) begin
            sel = s[2:0];
            foreach (at[i]) begin
                req(1, at[i], 24'h000010, SD_CMD_NOP);
                `CHK(sc, at[i] == 3'h2 || (at[i] == 3'h3 && s >= 2) || s == 3)
            end
        end
    endtask

    // sdram space ignores waits; commands on chip selects; reads per latency
    task automatic t_sdram;
        sel = SEL_SDRAM; wt = 16'hffff; stall = 1; pre = 1;
        req(1, 3'h5, 24'h8001aa, SD_CMD_WRITE);
        `CHK(cyc <= 5, 1'b1)
        `CHK({cs1[2], cs1[3], cs1[4]}, SD_CMD_WRITE)
        `CHK(a1, 24'h0005aa)
        @(posedge clk); #1;
        cs1 = chip_select_n;
        @(posedge clk); #1;
        `CHK(cs1[5] ^ chip_select_n[5], 1'b1)
        `CHK(oen, 1'b1)
        for (int l = 0; l < 4; l++) begin
            lat = l[1:0];
            req(0, 3'h2, 24'h000040, SD_CMD_READ);
            `CHK(rdata, 16'hc3a5)
            `CHK(cyc <= 13, 1'b1)
            // one wait for phase, command, then two system clocks per latency step
            `CHK(cyc, 6 + 2 * l)
        end
        stall = 0; wt = 16'h0000; pre = 0;
    endtask

    // refresh and ras-down levels in idle
    task automatic t_idle_dram;
        sel = SEL_DRAM_A2; refr = 1;
        repeat (2) @(posedge clk);
        #1;
        `CHK({chip_select_n[2], upper_byte_col_strobe, lower_byte_col_strobe}, 3'h0)
        refr = 0; rasdn = 1;
        req(1, 3'h2, 24'h000020, SD_CMD_NOP);
        repeat (2) @(posedge clk);
        #1;
        `CHK(chip_select_n[2], 1'b0)
        rasdn = 0;
        repeat (2) @(posedge clk);
        #1;
        `CHK(chip_select_n[2], 1'b1)
    endtask

    initial begin
        repeat (16) @(posedge clk);
        #1 rst_n = 1;
        @(posedge clk); #1;
        t_idle();
        t_write();
        t_decode();
        t_sdram();
        t_idle_dram();
        wrap_up();
    end
endmodule
